// >>> hw/asp_pkg.sv
package asp_pkg;
    // register addresses on the peripheral bus
    localparam logic [15:0] ADDR_COMM_CONTROL = 16'h7050;
    localparam logic [15:0] ADDR_CONTROL_ONE = 16'h7051;
    localparam logic [15:0] ADDR_BAUD_HIGH = 16'h7052;
    localparam logic [15:0] ADDR_BAUD_LOW = 16'h7053;
    localparam logic [15:0] ADDR_CONTROL_TWO = 16'h7054;
    localparam logic [15:0] ADDR_RX_STATUS = 16'h7055;
    localparam logic [15:0] ADDR_EMU_RX_BUF = 16'h7056;
    localparam logic [15:0] ADDR_RX_DATA_BUF = 16'h7057;
    localparam logic [15:0] ADDR_TX_DATA_BUF = 16'h7059;
    localparam logic [15:0] ADDR_PIN_CONTROL = 16'h705E;
    localparam logic [15:0] ADDR_PRIORITY = 16'h705F;

    // comm_control fields
    localparam int CC_CHAR_LO = 0;
    localparam int CC_CHAR_HI = 2;
    localparam int CC_ADDR_MODE = 3;
    localparam int CC_PAR_EN = 5;
    localparam int CC_EVEN_PAR = 6;
    localparam int CC_TWO_STOP = 7;

    // control_one fields
    localparam int C1_RX_EN = 0;
    localparam int C1_TX_EN = 1;
    localparam int C1_SLEEP = 2;
    localparam int C1_TX_WAKE = 3;
    localparam int C1_CLK_EN = 4;
    localparam int C1_SW_RST_N = 5;
    localparam int C1_RXERR_IE = 6;

    // control_two fields
    localparam int C2_TX_IE = 0;
    localparam int C2_RXBK_IE = 1;
    localparam int C2_TX_EMPTY = 6;
    localparam int C2_TX_RDY = 7;

    // receiver_status fields
    localparam int RS_RX_WAKE = 1;
    localparam int RS_PAR_ERR = 2;
    localparam int RS_OVR_ERR = 3;
    localparam int RS_FRM_ERR = 4;
    localparam int RS_BREAK = 5;
    localparam int RS_RX_RDY = 6;
    localparam int RS_RX_ERR = 7;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_BAUD = 16'h0000;

    // timing: eight sub-ticks per bit, sample in the middle
    localparam logic [2:0] SUB_LAST = 3'h7;
    localparam logic [2:0] SUB_MID = 3'h3;
    localparam logic [3:0] IDLE_BITS = 4'hA;
    localparam logic [3:0] WAKE_IDLE_BITS = 4'hB;
    localparam int FRAME_W = 13;
    localparam int RXS_W = 11;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_BITS = 2'b10
    } asp_rx_state_t;
endpackage : asp_pkg

// >>> hw/asp_baud_gen.sv
// sub-bit tick: one pulse every (divisor + 1) clocks, eight per bit
module asp_baud_gen (
    input wire logic clk, // system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic enable, // internal clock enable
    input wire logic [15:0] divisor, // bit-rate divisor
    output logic tick // one-cycle sub-bit pulse
);
    logic [15:0] cnt_q;

    // down counter reloads from divisor, so new rates take effect at wrap
    always_ff @(posedge clk) begin
        if (!rst_n || !enable) begin
            cnt_q <= asp_pkg::RST_BAUD;
            tick <= 1'b0;
        end else if (cnt_q == asp_pkg::RST_BAUD) begin
            cnt_q <= divisor;
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q - 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule // asp_baud_gen

// >>> hw/asp_serial_port.sv
// Overview of operation
// - tx shift register takes each buffered character, or 11 idle bits on an idle-line wake load, shifts it out per bit
// - rx shift register collects bits; character copied to both rx buffers
// - receiver and transmitter run independently, full duplex
// - line data is plain NRZ in both directions
// - frame is start, 1-8 data bits, optional parity, one or two stops
// - address-bit mode adds one bit marking address versus data
// - comm_control bits 2:0 choose character length one to eight
// - comm_control bit 5 enables parity generation and checking
// - comm_control bit 6 picks odd parity at 0, even at 1
// - comm_control bit 7 picks one or two transmitted stop bits
// - two byte registers hold the 16-bit bit-rate divisor
// - idle-line, address-bit and plain asynchronous modes supported
// - receiver_status has seven flags; control_two has tx flags and enables
// - control_one holds enables, wake, sleep, clock enable, software reset
// - bus bits 15:8 read undefined (zero here), writes there ignored
module asp_serial_port (
    input wire logic CLK, // system clock, 10 MHz
    input wire logic NRST, // synchronous reset, active low
    input wire logic [15:0] ADDR, // peripheral bus address
    input wire logic [15:0] WDATA, // peripheral bus write data
    input wire logic WE, // write strobe
    input wire logic RE, // read strobe
    output logic [15:0] RDATA, // read data, one cycle after RE
    input wire logic RX_DATA_PIN, // serial input from the peer
    output logic TX_DATA_PIN // serial output to the peer
);
    logic [7:0] comm_control_q, control_one_q, baud_hi_q, baud_lo_q;
    logic [7:0] ctl2_en_q, pin_control_q, priority_q;
    logic [7:0] tx_data_buffer_q, rx_data_buffer_q, emu_rx_buffer_q;
    logic tx_buf_full_q, tx_busy_q, idle_seen_q;
    logic [asp_pkg::FRAME_W-1:0] tx_shift_reg_q;
    logic [3:0] tx_left_q;
    logic [2:0] tx_sub_q;
    logic rx_meta_q, rx_sync_q;
    asp_pkg::asp_rx_state_t rx_state_q;
    logic [2:0] rx_sub_q;
    logic [3:0] rx_left_q, idle_cnt_q;
    logic [asp_pkg::RXS_W-1:0] rx_shift_reg_q;
    logic rx_wake_q, par_err_q, ovr_err_q, frm_err_q, brk_q, rx_rdy_q;
    logic tick, soft_rst_n, wr, rd, rx_done, tx_load;
    logic [3:0] char_len, rx_total;
    logic [7:0] rx_char;
    logic rx_addr, rx_par_bad, rx_stop_bad, rx_break, rx_is_addr;

    // frame bits, lsb first: start, data, address bit, parity, stop(s)
    function automatic logic [asp_pkg::FRAME_W-1:0] build_frame(
        input logic [7:0] data, input logic [3:0] len, input logic am,
        input logic abit, input logic pe, input logic even);
        logic [asp_pkg::FRAME_W-1:0] f;
        logic p;
        int pos;
        f = '1;
        p = ~even;
        pos = 1;
        f[0] = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (i < int'(len)) begin
                f[pos] = data[i];
                p = p ^ data[i];
                pos = pos + 1;
            end
        end
        if (am) begin
            f[pos] = abit;
            p = p ^ abit;
            pos = pos + 1;
        end
        if (pe) begin
            f[pos] = p;
        end
        return f;
    endfunction

    // bits after the start bit, up to and including the first stop
    function automatic logic [3:0] bits_after_start(
        input logic [3:0] len, input logic am, input logic pe);
        return len + {3'h0, am} + {3'h0, pe} + 4'h1;
    endfunction

    assign soft_rst_n = NRST && control_one_q[asp_pkg::C1_SW_RST_N];
    assign wr = WE && NRST;
    assign rd = RE && NRST;
    assign char_len = {1'b0, comm_control_q[asp_pkg::CC_CHAR_HI:
        asp_pkg::CC_CHAR_LO]} + 4'h1;
    assign rx_total = bits_after_start(char_len,
        comm_control_q[asp_pkg::CC_ADDR_MODE],
        comm_control_q[asp_pkg::CC_PAR_EN]);

    // shared sub-bit tick from the 16-bit divisor
    asp_baud_gen u_baud (
        .clk(CLK),
        .rst_n(soft_rst_n),
        .enable(control_one_q[asp_pkg::C1_CLK_EN]),
        .divisor({baud_hi_q, baud_lo_q}),
        .tick(tick)
    );

    // plain configuration registers; upper bus bits are dropped
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            comm_control_q <= asp_pkg::RST_BYTE;
            baud_hi_q <= asp_pkg::RST_BYTE;
            baud_lo_q <= asp_pkg::RST_BYTE;
            ctl2_en_q <= asp_pkg::RST_BYTE;
            pin_control_q <= asp_pkg::RST_BYTE;
            priority_q <= asp_pkg::RST_BYTE;
        end else if (wr) begin
            case (ADDR)
                asp_pkg::ADDR_COMM_CONTROL: comm_control_q <= WDATA[7:0];
                asp_pkg::ADDR_BAUD_HIGH: baud_hi_q <= WDATA[7:0];
                asp_pkg::ADDR_BAUD_LOW: baud_lo_q <= WDATA[7:0];
                asp_pkg::ADDR_CONTROL_TWO: ctl2_en_q <= WDATA[7:0];
                asp_pkg::ADDR_PIN_CONTROL: pin_control_q <= WDATA[7:0];
                asp_pkg::ADDR_PRIORITY: priority_q <= WDATA[7:0];
                default: ;
            endcase
        end
    end

    // control_one; a same-cycle write beats the load's wake clear
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            control_one_q <= asp_pkg::RST_BYTE;
        end else if (wr && ADDR == asp_pkg::ADDR_CONTROL_ONE) begin
            control_one_q <= WDATA[7:0];
        end else if (tx_load) begin
            control_one_q[asp_pkg::C1_TX_WAKE] <= 1'b0;
        end
    end

    // transmit buffer: cpu write fills it, shifter load empties it
    assign tx_load = tx_buf_full_q && !tx_busy_q
                     && control_one_q[asp_pkg::C1_TX_EN];
    always_ff @(posedge CLK) begin
        if (!soft_rst_n) begin
            tx_buf_full_q <= 1'b0;
            tx_data_buffer_q <= asp_pkg::RST_BYTE;
        end else if (wr && ADDR == asp_pkg::ADDR_TX_DATA_BUF) begin
            tx_data_buffer_q <= WDATA[7:0];
            tx_buf_full_q <= 1'b1;
        end else if (tx_load) begin
            tx_buf_full_q <= 1'b0;
        end
    end

    // transmit shifter; a wake load in idle-line mode sends 11 idle bits
    always_ff @(posedge CLK) begin
        if (!soft_rst_n) begin
            tx_busy_q <= 1'b0;
            tx_shift_reg_q <= '1;
            tx_left_q <= 4'h0;
            tx_sub_q <= 3'h0;
            TX_DATA_PIN <= 1'b1;
        end else if (tx_load) begin
            tx_busy_q <= 1'b1;
            tx_sub_q <= 3'h0;
            if (control_one_q[asp_pkg::C1_TX_WAKE]
                && !comm_control_q[asp_pkg::CC_ADDR_MODE]) begin
                tx_shift_reg_q <= '1;
                tx_left_q <= asp_pkg::WAKE_IDLE_BITS;
            end else begin
                tx_shift_reg_q <= build_frame(tx_data_buffer_q, char_len,
                    comm_control_q[asp_pkg::CC_ADDR_MODE],
                    control_one_q[asp_pkg::C1_TX_WAKE],
                    comm_control_q[asp_pkg::CC_PAR_EN],
                    comm_control_q[asp_pkg::CC_EVEN_PAR]);
                tx_left_q <= rx_total
                    + {3'h0, comm_control_q[asp_pkg::CC_TWO_STOP]}
                    + 4'h1;
            end
        end else if (tx_busy_q && tick) begin
            if (tx_sub_q == 3'h0) begin
                TX_DATA_PIN <= tx_shift_reg_q[0];
                tx_shift_reg_q <= {1'b1,
                    tx_shift_reg_q[asp_pkg::FRAME_W-1:1]};
            end
            tx_sub_q <= tx_sub_q + 3'h1;
            if (tx_sub_q == asp_pkg::SUB_LAST) begin
                tx_left_q <= tx_left_q - 4'h1;
                if (tx_left_q == 4'h1) begin
                    tx_busy_q <= 1'b0;
                end
            end
        end else if (!tx_busy_q) begin
            TX_DATA_PIN <= 1'b1;
        end
    end

    // two-flop synchroniser on the receive pin
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
        end else begin
            rx_meta_q <= RX_DATA_PIN;
            rx_sync_q <= rx_meta_q;
        end
    end

    // receive sequencer; sampling mid-bit tolerates 3/8 bit of skew
    always_ff @(posedge CLK) begin
        if (!soft_rst_n || !control_one_q[asp_pkg::C1_RX_EN]) begin
            rx_state_q <= asp_pkg::RX_IDLE;
            rx_sub_q <= 3'h0;
            rx_left_q <= 4'h0;
            rx_shift_reg_q <= '0;
        end else if (tick) begin
            rx_sub_q <= rx_sub_q + 3'h1;
            case (rx_state_q)
                asp_pkg::RX_IDLE: begin
                    if (!rx_sync_q) begin
                        rx_sub_q <= 3'h0;
                        rx_state_q <= asp_pkg::RX_START;
                    end
                end
                asp_pkg::RX_START: begin
                    if (rx_sub_q == asp_pkg::SUB_MID) begin
                        rx_sub_q <= 3'h0;
                        rx_left_q <= rx_total;
                        rx_state_q <= rx_sync_q ? asp_pkg::RX_IDLE
                                                : asp_pkg::RX_BITS;
                    end
                end
                asp_pkg::RX_BITS: begin
                    if (rx_sub_q == asp_pkg::SUB_LAST) begin
                        rx_shift_reg_q <= {rx_sync_q,
                            rx_shift_reg_q[asp_pkg::RXS_W-1:1]};
                        rx_left_q <= rx_left_q - 4'h1;
                        if (rx_left_q == 4'h1) begin
                            rx_state_q <= asp_pkg::RX_IDLE;
                        end
                    end
                end
                default: rx_state_q <= asp_pkg::RX_IDLE;
            endcase
        end
    end

    assign rx_done = tick && rx_state_q == asp_pkg::RX_BITS
                     && rx_sub_q == asp_pkg::SUB_LAST && rx_left_q == 4'h1;

    // decode the frame as it completes, stop bit arriving this cycle
    always_comb begin
        logic [asp_pkg::RXS_W-1:0] v;
        logic p;
        v = {rx_sync_q, rx_shift_reg_q[asp_pkg::RXS_W-1:1]}
            >> (asp_pkg::RXS_W - int'(rx_total));
        p = comm_control_q[asp_pkg::CC_EVEN_PAR];
        rx_char = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (i < int'(char_len)) begin
                rx_char[i] = v[i];
                p = p ^ v[i];
            end
        end
        rx_addr = v[char_len];
        if (comm_control_q[asp_pkg::CC_ADDR_MODE]) begin
            p = p ^ rx_addr;
        end
        rx_par_bad = comm_control_q[asp_pkg::CC_PAR_EN]
                     && (p ^ v[rx_total - 4'h2]) == 1'b0;
        rx_stop_bad = !rx_sync_q;
        rx_break = rx_stop_bad && v == '0;
        rx_is_addr = comm_control_q[asp_pkg::CC_ADDR_MODE] ? rx_addr
                                                           : idle_seen_q;
    end

    // ten idle bit times before a frame mark the next one as an address
    always_ff @(posedge CLK) begin
        if (!soft_rst_n) begin
            idle_cnt_q <= 4'h0;
            idle_seen_q <= 1'b0;
        end else if (rx_state_q != asp_pkg::RX_IDLE || !rx_sync_q) begin
            idle_cnt_q <= 4'h0;
            if (rx_done) begin
                idle_seen_q <= 1'b0;
            end
        end else if (tick && rx_sub_q == asp_pkg::SUB_LAST
                     && idle_cnt_q != asp_pkg::IDLE_BITS) begin
            idle_cnt_q <= idle_cnt_q + 4'h1; // whole idle bits
        end else if (idle_cnt_q == asp_pkg::IDLE_BITS) begin
            idle_seen_q <= 1'b1;
        end
    end

    // receive buffers and status; a new event beats a same-cycle clear
    always_ff @(posedge CLK) begin
        if (!soft_rst_n) begin
            rx_data_buffer_q <= asp_pkg::RST_BYTE;
            emu_rx_buffer_q <= asp_pkg::RST_BYTE;
            {rx_wake_q, par_err_q, ovr_err_q, frm_err_q} <= 4'h0;
            {brk_q, rx_rdy_q} <= 2'b00;
        end else if (rx_done && (!control_one_q[asp_pkg::C1_SLEEP]
                                 || rx_is_addr)) begin
            rx_data_buffer_q <= rx_char;
            emu_rx_buffer_q <= rx_char;
            rx_wake_q <= rx_is_addr;
            par_err_q <= par_err_q | rx_par_bad;
            frm_err_q <= frm_err_q | rx_stop_bad;
            brk_q <= brk_q | rx_break;
            ovr_err_q <= ovr_err_q | (rx_rdy_q && !(rd
                && ADDR == asp_pkg::ADDR_RX_DATA_BUF));
            rx_rdy_q <= 1'b1;
        end else if (rd && ADDR == asp_pkg::ADDR_RX_DATA_BUF) begin
            rx_rdy_q <= 1'b0;
        end
    end

    // read data registered; bits 15:8 are driven as zero
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            RDATA <= 16'h0000;
        end else if (rd) begin
            RDATA <= 16'h0000;
            case (ADDR)
                asp_pkg::ADDR_COMM_CONTROL: RDATA[7:0] <= comm_control_q;
                asp_pkg::ADDR_CONTROL_ONE: RDATA[7:0] <= control_one_q;
                asp_pkg::ADDR_BAUD_HIGH: RDATA[7:0] <= baud_hi_q;
                asp_pkg::ADDR_BAUD_LOW: RDATA[7:0] <= baud_lo_q;
                asp_pkg::ADDR_CONTROL_TWO: begin
                    RDATA[asp_pkg::C2_TX_IE] <= ctl2_en_q[asp_pkg::C2_TX_IE];
                    RDATA[asp_pkg::C2_RXBK_IE] <= ctl2_en_q[asp_pkg::C2_RXBK_IE];
                    RDATA[asp_pkg::C2_TX_EMPTY] <=
                        !tx_buf_full_q && !tx_busy_q;
                    RDATA[asp_pkg::C2_TX_RDY] <= !tx_buf_full_q;
                end
                asp_pkg::ADDR_RX_STATUS: begin
                    RDATA[asp_pkg::RS_RX_WAKE] <= rx_wake_q;
                    RDATA[asp_pkg::RS_PAR_ERR] <= par_err_q;
                    RDATA[asp_pkg::RS_OVR_ERR] <= ovr_err_q;
                    RDATA[asp_pkg::RS_FRM_ERR] <= frm_err_q;
                    RDATA[asp_pkg::RS_BREAK] <= brk_q;
                    RDATA[asp_pkg::RS_RX_RDY] <= rx_rdy_q;
                    RDATA[asp_pkg::RS_RX_ERR] <=
                        par_err_q | ovr_err_q | frm_err_q | brk_q;
                end
                asp_pkg::ADDR_EMU_RX_BUF: RDATA[7:0] <= emu_rx_buffer_q;
                asp_pkg::ADDR_RX_DATA_BUF: RDATA[7:0] <= rx_data_buffer_q;
                asp_pkg::ADDR_PIN_CONTROL: RDATA[7:0] <= pin_control_q;
                asp_pkg::ADDR_PRIORITY: RDATA[7:0] <= priority_q;
                default: ;
            endcase
        end
    end
endmodule // asp_serial_port

// >>> test/asp_serial_port_sva.sv
module asp_serial_port_sva (
    input wire logic CLK, // system clock
    input wire logic NRST, // synchronous reset, active low
    input wire logic [15:0] ADDR, // bus address
    input wire logic [15:0] WDATA, // bus write data
    input wire logic WE, // write strobe
    input wire logic RE, // read strobe
    input wire logic [15:0] RDATA, // read data
    input wire logic RX_DATA_PIN, // serial input
    input wire logic TX_DATA_PIN // serial output
);
    logic [7:0] cc_q, c1_q, hb_q, lb_q;
    logic tx_q;
    logic [19:0] run_q, bit_len;

    // clocks per line bit, from the shadowed divisor
    assign bit_len = {1'b0, hb_q, lb_q, 3'h0} + 20'h00008;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);

    // shadow copies of the config bytes as the bus writes them
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            cc_q <= 8'h00;
            c1_q <= 8'h00;
            hb_q <= 8'h00;
            lb_q <= 8'h00;
        end else if (WE) begin
            case (ADDR)
                asp_pkg::ADDR_COMM_CONTROL: cc_q <= WDATA[7:0];
                asp_pkg::ADDR_CONTROL_ONE: c1_q <= WDATA[7:0];
                asp_pkg::ADDR_BAUD_HIGH: hb_q <= WDATA[7:0];
                asp_pkg::ADDR_BAUD_LOW: lb_q <= WDATA[7:0];
                default: ;
            endcase
        end
    end

    // length of the current line level
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            tx_q <= 1'b1;
            run_q <= 20'h00000;
        end else begin
            tx_q <= TX_DATA_PIN;
            run_q <= (TX_DATA_PIN != tx_q) ? 20'h00001 : run_q + 20'h00001;
        end
    end

    a_upper_zero: assert property (
        RDATA[15:8] == 8'h00) else $error("upper read bits not zero");
    a_reset_idle: assert property (
        $rose(NRST) |-> TX_DATA_PIN && RDATA == 16'h0000)
        else $error("not idle after reset");
    a_unmapped_zero: assert property (
        RE && (ADDR == 16'h7058 || (ADDR >= 16'h705A && ADDR <= 16'h705D))
        |=> RDATA == 16'h0000) else $error("reserved read not zero");
    a_format_back: assert property (
        RE && ADDR == asp_pkg::ADDR_COMM_CONTROL |=> RDATA[7:0] == $past(cc_q))
        else $error("comm_control readback wrong");
    a_baud_hi_back: assert property (
        RE && ADDR == asp_pkg::ADDR_BAUD_HIGH |=> RDATA[7:0] == $past(hb_q))
        else $error("baud high readback wrong");
    a_baud_lo_back: assert property (
        RE && ADDR == asp_pkg::ADDR_BAUD_LOW |=> RDATA[7:0] == $past(lb_q))
        else $error("baud low readback wrong");
    a_swrst_idle: assert property (
        !c1_q[5] [*4] |-> TX_DATA_PIN)
        else $error("line active in software reset");
    a_bit_align: assert property (
        !tx_q && TX_DATA_PIN |-> run_q % bit_len == 20'h00000)
        else $error("low run not whole bit periods");
endmodule // asp_serial_port_sva

bind asp_serial_port asp_serial_port_sva u_asp_serial_port_sva (
    .CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WE(WE),
    .RE(RE), .RDATA(RDATA), .RX_DATA_PIN(RX_DATA_PIN),
    .TX_DATA_PIN(TX_DATA_PIN));

// >>> test/asp_peer_model.sv
module asp_peer_model #(
    parameter int BIT = 16 // clocks per line bit
) (
    input wire logic clk, // bench clock
    output logic rx_pin, // drives the design's receive pin
    input wire logic tx_pin // watches the design's transmit pin
);
    timeunit 1ns;
    timeprecision 1ns;
    int nbits = 10; // bits after start, stops too
    logic [11:0] rxq [$]; // captured frames

    // line idles high between frames
    initial rx_pin = 1'b1;

    // nrz frame, lsb first
    task send(input logic [11:0] f, input int n);
        rx_pin <= 1'b0;
        repeat (BIT) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            rx_pin <= f[i];
            repeat (BIT) @(posedge clk);
        end
        rx_pin <= 1'b1;
    endtask

    // sample each bit in its middle
    initial begin : capture
        logic [11:0] f;
        forever begin
            @(negedge tx_pin);
            f = 12'hFFF;
            repeat (BIT / 2) @(posedge clk);
            for (int i = 0; i < nbits; i++) begin
                repeat (BIT) @(posedge clk);
                f[i] = tx_pin;
            end
            rxq.push_back(f);
        end
    end
endmodule // asp_peer_model

// >>> test/test_async_serial_port.sv
module test_async_serial_port;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BIT = 16;
    localparam logic [15:0] CC = asp_pkg::ADDR_COMM_CONTROL;
    localparam logic [15:0] C1 = asp_pkg::ADDR_CONTROL_ONE;
    localparam logic [15:0] C2 = asp_pkg::ADDR_CONTROL_TWO;
    localparam logic [15:0] RS = asp_pkg::ADDR_RX_STATUS;
    localparam logic [15:0] TB = asp_pkg::ADDR_TX_DATA_BUF;
    logic CLK = 1'b0;
    logic NRST = 1'b0;
    logic [15:0] ADDR = 16'h0000;
    logic [15:0] WDATA = 16'h0000;
    logic WE = 1'b0;
    logic RE = 1'b0;
    logic [15:0] RDATA;
    logic RX_DATA_PIN;
    logic TX_DATA_PIN;
    int num_errors = 0;
    int tests_run = 0;
    int seed = 32'hE56F;
    int i, n;
    logic [15:0] a, d, v;
    logic [7:0] d1, d2, dr;
    logic [11:0] f;
    logic pe, ev, st;
    logic [15:0] rw [5] = '{16'h7050, 16'h7052, 16'h7053, 16'h705E, 16'h705F};
    logic [7:0] errs [4] = '{8'h84, 8'h90, 8'hB0, 8'h88};

    always #50 CLK = ~CLK;

    asp_serial_port u_asp_serial_port (.CLK(CLK), .NRST(NRST), .ADDR(ADDR),
        .WDATA(WDATA), .WE(WE), .RE(RE), .RDATA(RDATA),
        .RX_DATA_PIN(RX_DATA_PIN), .TX_DATA_PIN(TX_DATA_PIN));
    asp_peer_model #(.BIT(BIT)) u_asp_peer_model (.clk(CLK),
        .rx_pin(RX_DATA_PIN), .tx_pin(TX_DATA_PIN));

    task test_done;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task hang;
        num_errors++;
        $display("BAD %0t wait ran out", $time);
        test_done;
    endtask
    task chk8(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %0t byte %h expected %h", $time, g, e);
        end
    endtask
    task chkf(input logic [11:0] g, input logic [11:0] e);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %0t frame %h expected %h", $time, g, e);
        end
    endtask
    task wr(input logic [15:0] ad, input logic [15:0] wv);
        @(posedge CLK);
        ADDR <= ad;
        WDATA <= wv;
        WE <= 1'b1;
        @(posedge CLK);
        WE <= 1'b0;
    endtask
    // rdata is registered: take it after the edge
    task rd(input logic [15:0] ad, output logic [15:0] rv);
        @(posedge CLK);
        ADDR <= ad;
        RE <= 1'b1;
        @(posedge CLK);
        RE <= 1'b0;
        #1 rv = RDATA;
    endtask
    task wait_bit(input logic [15:0] ad, input int b);
        logic [15:0] r;
        r = 16'h0000;
        for (int k = 0; k < 3000 && r[b] !== 1'b1; k++) rd(ad, r);
        if (r[b] !== 1'b1) hang;
    endtask
    task wait_q;
        for (int k = 0; k < 5000 && u_asp_peer_model.rxq.size() < 2; k++)
            @(posedge CLK);
        if (u_asp_peer_model.rxq.size() < 2) hang;
    endtask
    // line bits after start: data lsb first, address bit, parity, stops
    function automatic logic [11:0] frm(input logic [7:0] x, input int m,
        input logic p, input logic e, input logic am, input logic ab);
        logic [11:0] r;
        int k;
        r = 12'hFFF;
        for (k = 0; k < m; k++) r[k] = x[k];
        if (am) begin
            r[k] = ab;
            k++;
        end
        if (p) r[k] = ^(x & (8'hFF >> (8 - m))) ^ (am & ab) ^ !e;
        return r;
    endfunction

    initial begin
        repeat (16) @(posedge CLK);
        NRST <= 1'b1;
        // zero after reset, but for the two idle tx flags
        for (a = 16'h7050; a <= 16'h705F; a++) begin
            if (a != TB) begin
                rd(a, d);
                chk8(d[7:0], a == C2 ? 8'hC0 : 8'h00);
            end
        end
        // random bytes, junk in upper half
        for (i = 0; i < 20; i++) begin
            v = 16'($random(seed));
            wr(rw[i % 5], v);
            rd(rw[i % 5], d);
            chk8(d[7:0], v[7:0]);
        end
        // 16 clocks per bit, engines out of software reset
        wr(asp_pkg::ADDR_BAUD_HIGH, 16'h0000);
        wr(asp_pkg::ADDR_BAUD_LOW, 16'h0001);
        wr(C2, 16'hFF03);
        wr(C1, 16'h0033);
        rd(C2, d);
        chk8(d[7:0], 8'hC3);
        // every length, parity mode and stop count, both ways at once
        for (i = 0; i < 24; i++) begin
            n = i % 8 + 1;
            pe = i >= 8;
            ev = i >= 16;
            st = i[1] ^ i[3];
            d1 = 8'($random(seed));
            d2 = 8'($random(seed));
            dr = 8'($random(seed));
            wr(CC, {8'h00, st, ev, pe, 2'b00, 3'(n - 1)});
            u_asp_peer_model.nbits = n + pe + 1 + st;
            fork
                u_asp_peer_model.send(frm(dr, n, pe, ev, 0, 0), n + pe + 1);
                begin
                    wr(TB, {8'h00, d1});
                    wait_bit(C2, 7);
                    wr(TB, {8'h00, d2});
                end
            join
            wait_q;
            f = frm(d1, n, pe, ev, 0, 0);
            chkf(u_asp_peer_model.rxq.pop_front(), f);
            f = frm(d2, n, pe, ev, 0, 0);
            chkf(u_asp_peer_model.rxq.pop_front(), f);
            wait_bit(RS, 6);
            rd(16'h7057, d);
            chk8(d[7:0], dr & (8'hFF >> (8 - n)));
            rd(asp_pkg::ADDR_EMU_RX_BUF, d);
            chk8(d[7:0], dr & (8'hFF >> (8 - n)));
            rd(RS, d);
            chk8(d[7:0] & 8'hBD, 8'h00);
        end
        // parity, framing, break and overrun, cleared by software reset
        for (i = 0; i < 4; i++) begin
            ev = i == 2;
            dr = (i == 2) ? 8'h00 : 8'($random(seed));
            wr(CC, {8'h00, 1'b0, ev, 6'h27});
            f = frm(dr, 8, 1'b1, ev, 1'b0, 1'b0);
            if (i == 0) f[8] = ~f[8];
            if (i == 1 || i == 2) f[9] = 1'b0;
            u_asp_peer_model.send(f, 10);
            if (i == 3) u_asp_peer_model.send(f, 10);
            repeat (8) @(posedge CLK);
            rd(RS, d);
            chk8(d[7:0] & 8'hBC, errs[i]);
            wr(C1, 16'h0013);
            wr(C1, 16'h0033);
            rd(RS, d);
            chk8(d[7:0] & 8'hBC, 8'h00);
        end
        // address-bit mode: wake marks the first frame only
        wr(CC, 16'h000F);
        u_asp_peer_model.nbits = 10;
        fork
            u_asp_peer_model.send(frm(dr, 8, 0, 0, 1, 1), 10);
            begin
                wr(C1, 16'h003B);
                wr(TB, {8'h00, d1});
                wait_bit(C2, 7);
                wr(TB, {8'h00, d2});
            end
        join
        wait_q;
        f = frm(d1, 8, 0, 0, 1, 1);
        chkf(u_asp_peer_model.rxq.pop_front(), f);
        f = frm(d2, 8, 0, 0, 1, 0);
        chkf(u_asp_peer_model.rxq.pop_front(), f);
        rd(RS, d);
        chk8(d[7:0] & 8'h42, 8'h42);
        rd(C1, d);
        chk8(d[7:0], 8'h33);
        wait_bit(C2, 6);
        rd(C2, d);
        chk8(d[7:0], 8'hC3);
        test_done;
    end
endmodule // test_async_serial_port
